// File: testbench/skl_top_bench.sv
// Self-checking bench for the key lock register bank.
// Assumes the APB slave answers one access cycle after setup; the bench drives every port itself.
`timescale 1ns/10ps
module skl_top_bench;
  import skl_pkg::*;
  localparam logic [31:0] A_KEY  = 32'(SKL_OFF_KEY);
  localparam logic [31:0] A_GATE = 32'(SKL_OFF_GATE);
  localparam logic [31:0] A_PWR  = 32'(SKL_OFF_PWR);
  localparam logic [31:0] A_CFG  = 32'(SKL_OFF_CFG);
  localparam logic [31:0] A_ID   = 32'(SKL_OFF_ID);
  localparam logic [31:0] A_MDIS = 32'(SKL_OFF_MDIS);
  logic         i_clock = 1'b0;
  logic         i_arst_n = 1'b0;
  logic         i_psel = 1'b0;
  logic         i_penable = 1'b0;
  logic         i_pwrite = 1'b0;
  logic [31:0]  i_paddr = 32'h0;
  logic [31:0]  i_pwdata = 32'h0;
  logic         i_other_wr = 1'b0;
  logic         i_sleep_req = 1'b0;
  logic         i_wake = 1'b0;
  logic         i_ret_cfg = 1'b1;
  logic         i_lp_en = 1'b0;
  logic         i_main_bor_en = 1'b1;
  logic         o_pready;
  logic         o_pslverr;
  logic [31:0]  o_prdata;
  skl_mdis_t    o_mdis;
  skl_reg_ctl_t o_reg_ctl;
  logic         o_lp_on;
  logic [7:0]   o_exec;
  logic         o_unlocked;
  int           error_cnt = 0;
  int           n_compared = 0;
  int           n_try = 0;
  logic [31:0]  q;
  logic         e;
  logic [31:0]  base;
  logic [31:0]  m;

  // Free-running system clock
  always #5 i_clock = ~i_clock;

  skl_top u_skl_top (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_other_wr(i_other_wr),
    .i_sleep_req(i_sleep_req), .i_wake(i_wake), .i_retention_config_bit(i_ret_cfg),
    .i_low_power_brownout_enable(i_lp_en), .i_main_bor_en(i_main_bor_en),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .o_module_disable_bit(o_mdis), .o_reg_ctl(o_reg_ctl), .o_lp_brownout_on(o_lp_on),
    .o_ram_exec_boundary(o_exec), .o_unlocked(o_unlocked));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // One APB transfer; idle cycle after it avoids double assignment at one edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n = 0;
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    @(posedge i_clock);
    while (o_pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge i_clock);
    end
    if (n == 20) chk(32'h0, 32'h1);
    rq = o_prdata;
    re = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
    @(posedge i_clock);
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, a, d, rq, re);
    chk({31'h0, re}, 32'h0);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rq;
    logic        re;
    apb(1'b0, a, 32'h0, rq, re);
    chk(rq, exp);
    chk({31'h0, re}, 32'h0);
  endtask : rd

  task automatic unlock();
    wr(A_KEY, 32'h0);
    wr(A_KEY, SKL_KEY_FIRST);
    wr(A_KEY, SKL_KEY_SECOND);
  endtask : unlock

  // Sleep, wake, then count held-off cycles
  task automatic sleep_wake(input logic [3:0] exp_ctl, input int exp_hold);
    int n = 0;
    i_sleep_req <= 1'b1;
    @(posedge i_clock);
    i_sleep_req <= 1'b0;
    @(posedge i_clock);
    chk({28'h0, o_reg_ctl}, {28'h0, exp_ctl});
    i_wake <= 1'b1;
    @(posedge i_clock);
    i_wake <= 1'b0;
    @(posedge i_clock);
    while (o_reg_ctl.exec_hold === 1'b1 && n < 1100) begin
      n++;
      @(posedge i_clock);
    end
    chk(32'(n), 32'(exp_hold));
    chk({28'h0, o_reg_ctl}, 32'h0);
  endtask : sleep_wake

  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge i_clock);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(posedge i_clock);
    // Reset values and plain decode
    rd(A_KEY, 32'h0);
    rd(A_GATE, 32'h0);
    rd(A_PWR, 32'h0);
    rd(A_CFG, 32'h0);
    rd(A_ID, SKL_PART_ID);
    apb(1'b0, 32'h00000ff0, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Locked write dropped, then unlock opens it
    wr(A_PWR, 32'h3);
    rd(A_PWR, 32'h0);
    unlock();
    rd(A_KEY, 32'h1);
    chk({31'h0, o_unlocked}, 32'h1);
    wr(A_PWR, 32'h3);
    rd(A_PWR, 32'h3);
    wr(A_KEY, SKL_KEY_FIRST);
    rd(A_KEY, 32'h1);
    wr(A_KEY, 32'h0);
    rd(A_KEY, 32'h0);
    wr(A_PWR, 32'h0);
    rd(A_PWR, 32'h3);
    // Broken sequences: foreign APB write, other master, wrong word, repeated first word
    for (int k = 0; k < 4; k++) begin
      wr(A_KEY, 32'h0);
      wr(A_KEY, SKL_KEY_FIRST);
      if (k == 0) wr(A_CFG, 32'h0);
      if (k == 1) begin
        i_other_wr <= 1'b1;
        @(posedge i_clock);
        i_other_wr <= 1'b0;
        @(posedge i_clock);
      end
      if (k == 2) wr(A_KEY, 32'h12345678);
      if (k == 3) wr(A_KEY, SKL_KEY_FIRST);
      wr(A_KEY, SKL_KEY_SECOND);
      rd(A_KEY, 32'h0);
    end
    // Retry until the key register reads open; first try is broken
    q = 32'h0;
    while (q !== 32'h1 && n_try < 3) begin
      wr(A_KEY, 32'h0);
      wr(A_KEY, SKL_KEY_FIRST);
      if (n_try == 0) wr(A_CFG, 32'h0);
      wr(A_KEY, SKL_KEY_SECOND);
      apb(1'b0, A_KEY, 32'h0, q, e);
      n_try++;
    end
    chk(32'(n_try), 32'h2);
    // Reads between key words do not abort
    wr(A_KEY, 32'h0);
    wr(A_KEY, SKL_KEY_FIRST);
    rd(A_KEY, 32'h0);
    wr(A_KEY, SKL_KEY_SECOND);
    rd(A_KEY, 32'h1);
    // Gate lock freezes disable registers
    wr(A_GATE, 32'h1 << SKL_GATE_LOCK_BIT);
    wr(A_KEY, 32'h0);
    wr(A_GATE, 32'h0);
    rd(A_GATE, 32'h1 << SKL_GATE_LOCK_BIT);
    wr(A_MDIS, 32'h1);
    rd(A_MDIS, 32'h0);
    chk(o_mdis[0], 32'h0);
    unlock();
    wr(A_GATE, 32'h0);
    wr(A_KEY, 32'h0);
    // Every disable register through all aliases
    for (int i = 0; i < SKL_NUM_MDIS; i++) begin
      base = A_MDIS + 32'(i * 16);
      m = SKL_MDIS_MASK[i];
      wr(base, 32'hffffffff);
      rd(base, m);
      chk(o_mdis[i], m);
      wr(base + 32'h4, m & 32'h0000ffff);
      rd(base, m & 32'hffff0000);
      wr(base + 32'hc, 32'hffffffff);
      rd(base + 32'hc, m & 32'h0000ffff);
      wr(base + 32'h4, 32'hffffffff);
      rd(base + 32'h4, 32'h0);
      wr(base + 32'h8, m & 32'hff00ff00);
      rd(base + 32'h8, m & 32'hff00ff00);
      chk(o_mdis[i], m & 32'hff00ff00);
      wr(base, 32'h0);
    end
    // Execution boundary and read-only identifier
    wr(A_CFG, 32'hffffffff);
    rd(A_CFG, 32'h000000ff);
    chk({24'h0, o_exec}, 32'h000000ff);
    wr(A_ID, 32'h0);
    rd(A_ID, SKL_PART_ID);
    // Power: keepalive set without retention fuse gives light sleep
    sleep_wake(4'b0000, 0);
    i_ret_cfg <= 1'b0;
    repeat (4) @(posedge i_clock);
    sleep_wake(4'b0110, SKL_REGULATOR_STARTUP_DELAY_CYC);
    i_ret_cfg <= 1'b1;
    unlock();
    wr(A_PWR, 32'h0);
    wr(A_KEY, 32'h0);
    sleep_wake(4'b1000, SKL_REGULATOR_STARTUP_DELAY_CYC);
    // Low-power brown-out only while the main detector is off
    chk({31'h0, o_lp_on}, 32'h0);
    i_lp_en <= 1'b1;
    i_main_bor_en <= 1'b0;
    repeat (5) @(posedge i_clock);
    chk({31'h0, o_lp_on}, 32'h1);
    i_main_bor_en <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk({31'h0, o_lp_on}, 32'h0);
    conclude();
  end
endmodule : skl_top_bench

// File: verilog/skl_key_seq.sv
// Two-word unlock sequencer for the protected registers.
// Assumes one-cycle write strobes on the system clock.
`timescale 1ns/10ps
module skl_key_seq import skl_pkg::*; (
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        i_key_wr,
  input  wire logic        i_other_wr,
  input  wire logic [31:0] i_wdata,
  output logic             o_unlocked
);
  skl_key_st_t st_r;
  skl_key_st_t st_nxt;

  // Next state of the sequence
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SKL_KS_LOCKED: begin
        if (i_key_wr && i_wdata == SKL_KEY_FIRST)
          st_nxt = SKL_KS_FIRST;
      end
      SKL_KS_FIRST: begin
        if (i_key_wr && i_wdata == SKL_KEY_SECOND)
          st_nxt = SKL_KS_OPEN;
        else if (i_key_wr || i_other_wr)
          st_nxt = SKL_KS_LOCKED;
      end
      SKL_KS_OPEN: begin
        // Key words keep it open, any other word written to the key register relocks
        if (i_key_wr && i_wdata != SKL_KEY_FIRST && i_wdata != SKL_KEY_SECOND)
          st_nxt = SKL_KS_LOCKED;
      end
      default: st_nxt = SKL_KS_LOCKED;
    endcase
  end

  // Sequence state
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      st_r <= SKL_KS_LOCKED;
    else
      st_r <= st_nxt;
  end

  // Open flag kept in a flop so the top output is registered
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      o_unlocked <= 1'b0;
    else
      o_unlocked <= (st_nxt == SKL_KS_OPEN);
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  // Key writes are exactly three cycles apart, with two idle bus cycles between
  sequence s_key_pair;
    (i_key_wr && i_wdata == SKL_KEY_FIRST && st_r == SKL_KS_LOCKED) ##1
    (!i_key_wr && !i_other_wr) [*2] ##1 (i_key_wr && i_wdata == SKL_KEY_SECOND);
  endsequence

  chk_unlock_pair: assert property (s_key_pair |=> o_unlocked)
    else $error("key pair did not unlock");
  chk_relock_write: assert property (o_unlocked && i_key_wr &&
    i_wdata != SKL_KEY_FIRST && i_wdata != SKL_KEY_SECOND |=> !o_unlocked)
    else $error("non-key write did not relock");
  chk_abort_foreign: assert property (st_r == SKL_KS_FIRST &&
    i_other_wr |=> !o_unlocked ##1 !o_unlocked)
    else $error("foreign write did not abort sequence");
  chk_bad_first: assert property (i_key_wr &&
    ((st_r == SKL_KS_LOCKED && i_wdata != SKL_KEY_FIRST) ||
    (st_r == SKL_KS_FIRST && i_wdata != SKL_KEY_SECOND)) |=> st_r == SKL_KS_LOCKED)
    else $error("bad key word did not reset sequence");
endmodule : skl_key_seq

// File: verilog/skl_pkg.sv
// Constants, types and helpers of the key lock block.
// Assumes a 32-bit APB bus and a 100 MHz system clock.
package skl_pkg;
  // Register byte offsets
  localparam logic [11:0] SKL_OFF_KEY  = 12'h000;
  localparam logic [11:0] SKL_OFF_GATE = 12'h010;
  localparam logic [11:0] SKL_OFF_PWR  = 12'h020;
  localparam logic [11:0] SKL_OFF_CFG  = 12'h030;
  localparam logic [11:0] SKL_OFF_ID   = 12'h040;
  localparam logic [11:0] SKL_OFF_MDIS = 12'h100;
  localparam int          SKL_NUM_MDIS = 7;
  // Alias codes, offsets 0x0/0x4/0x8/0xc
  localparam logic [1:0] SKL_OP_WR  = 2'h0;
  localparam logic [1:0] SKL_OP_CLR = 2'h1;
  localparam logic [1:0] SKL_OP_SET = 2'h2;
  localparam logic [1:0] SKL_OP_INV = 2'h3;
  // Key words
  localparam logic [31:0] SKL_KEY_FIRST  = 32'haa996655;
  localparam logic [31:0] SKL_KEY_SECOND = 32'h556699aa;
  // Field positions
  localparam int SKL_GATE_LOCK_BIT = 11;
  localparam int SKL_KEEPALIVE_BIT = 0;
  localparam int SKL_RET_EN_BIT    = 1;
  // Reset values
  localparam logic        SKL_GATE_LOCK_RST = 1'b0;
  localparam logic [1:0]  SKL_PWR_RST       = 2'h0;
  localparam logic [7:0]  SKL_EXEC_RST      = 8'h00;
  localparam logic [31:0] SKL_MDIS_RST      = 32'h00000000;
  // Arbitrary part code, names no real part
  localparam logic [31:0] SKL_PART_ID = 32'h00a5c001;
  // Implemented bits of each module disable register
  localparam logic [31:0] SKL_MDIS_MASK [SKL_NUM_MDIS] = '{
    32'h00101001, 32'h0f000007, 32'h0001ff00, 32'h00000007,
    32'h01070707, 32'h00000101, 32'h00000010};
  // Regulator start-up time
  localparam int SKL_CLK_NS     = 10;
  localparam int SKL_REGULATOR_STARTUP_DELAY_NS   = 10000;
  localparam int SKL_REGULATOR_STARTUP_DELAY_CYC  = (SKL_REGULATOR_STARTUP_DELAY_NS + SKL_CLK_NS - 1) / SKL_CLK_NS;
  localparam logic [10:0] SKL_REGULATOR_STARTUP_DELAY_LAST = 11'(SKL_REGULATOR_STARTUP_DELAY_CYC - 1);

  typedef enum logic [1:0] {
    SKL_KS_LOCKED = 2'b00,
    SKL_KS_FIRST  = 2'b01,
    SKL_KS_OPEN   = 2'b10
  } skl_key_st_t;

  typedef enum logic [1:0] {
    SKL_PS_RUN   = 2'b00,
    SKL_PS_SLEEP = 2'b01,
    SKL_PS_DEEP  = 2'b10,
    SKL_PS_WAKE  = 2'b11
  } skl_pwr_st_t;

  // Regulator control outputs
  typedef struct packed {
    logic main_standby;
    logic main_off;
    logic retention_on;
    logic exec_hold;
  } skl_reg_ctl_t;

  typedef logic [SKL_NUM_MDIS-1:0][31:0] skl_mdis_t;

  // Apply a plain, clear, set or invert write
  function automatic logic [31:0] skl_alias(input logic [1:0] op,
    input logic [31:0] cur, input logic [31:0] wd, input logic [31:0] msk);
    logic [31:0] r;
    r = wd;
    case (op)
      SKL_OP_CLR: r = cur & ~wd;
      SKL_OP_SET: r = cur | wd;
      SKL_OP_INV: r = cur ^ wd;
      default:    r = wd;
    endcase
    return r & msk;
  endfunction : skl_alias
endpackage : skl_pkg

// File: verilog/skl_top.sv
// Key lock, module gating and power control register bank.
// Assumes an APB master on i_clock; fuse levels are asynchronous.
// Behaviour
// - Locked protected registers ignore writes
// - Unlocked until non-key word written
// - Foreign write aborts unlock sequence
// - Power control is key protected
// - Clear, set, invert aliases per disable
// - Unimplemented disable bits read zero
// - Keepalive clear puts regulator in standby
// - Retention regulator on, main off
// - Hold execution for regulator startup
// - Low-power detector only without main
// - Read-only part identifier register
// - Gate lock ignores disable register writes
// - Disable bit stops peripheral clocks; here only driven out, clocks gated outside
// - Key register reads lock state
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module skl_top import skl_pkg::*; (
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_other_wr,
  input  wire logic        i_sleep_req,
  input  wire logic        i_wake,
  input  wire logic        i_retention_config_bit,
  input  wire logic        i_low_power_brownout_enable,
  input  wire logic        i_main_bor_en,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  output skl_mdis_t        o_module_disable_bit,
  output skl_reg_ctl_t     o_reg_ctl,
  output logic             o_lp_brownout_on,
  output logic [7:0]       o_ram_exec_boundary,
  output logic             o_unlocked
);
  // Bus and decode signals
  logic            setup;
  logic            acc_wr;
  logic [11:0]     off;
  logic [2:0]      md_idx;
  logic [1:0]      md_op;
  logic            hit_md;
  logic            hit_any;
  logic            unlocked;
  logic [31:0]     rd_mux;
  logic            pready_r;
  logic            pslverr_r;
  logic [31:0]     prdata_r;
  // Register state
  logic            gate_lock_r;
  logic [1:0]      pwr_r;
  logic [7:0]      exec_r;
  skl_mdis_t       mdis_r;
  // Fuse level synchronisers
  logic [2:0]      fuse_s1_r;
  logic [2:0]      fuse_s2_r;
  // Power sequencing
  skl_pwr_st_t     ps_r;
  skl_pwr_st_t     ps_nxt;
  logic [10:0]     tv_cnt_r;
  logic            deep_ret_r;
  logic            ret_active;
  skl_reg_ctl_t    ctl_r;
  logic            lpbor_r;

  // Access phase write and decoded target
  assign setup   = i_psel && !i_penable;
  assign acc_wr  = i_psel && i_penable && pready_r && i_pwrite;
  assign off     = i_paddr[11:0];
  assign md_idx  = off[6:4];
  assign md_op   = off[3:2];
  assign hit_md  = off[11:7] == SKL_OFF_MDIS[11:7] && md_idx < 3'h7;
  assign hit_any = hit_md || off == SKL_OFF_KEY || off == SKL_OFF_GATE
                || off == SKL_OFF_PWR || off == SKL_OFF_CFG
                || off == SKL_OFF_ID;

  // Unlock sequence; writes to other registers and other slaves' writes count, reads do not
  skl_key_seq u_key (
    .i_clock    (i_clock),
    .i_arst_n   (i_arst_n),
    .i_key_wr   (acc_wr && off == SKL_OFF_KEY),
    .i_other_wr (i_other_wr || (acc_wr && off != SKL_OFF_KEY)),
    .i_wdata    (i_pwdata),
    .o_unlocked (unlocked)
  );

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h00000000;
    if (off == SKL_OFF_KEY)
      rd_mux = {31'h0, unlocked};
    else if (off == SKL_OFF_GATE)
      rd_mux[SKL_GATE_LOCK_BIT] = gate_lock_r;
    else if (off == SKL_OFF_PWR)
      rd_mux = {30'h0, pwr_r};
    else if (off == SKL_OFF_CFG)
      rd_mux = {24'h000000, exec_r};
    else if (off == SKL_OFF_ID)
      rd_mux = SKL_PART_ID;
    else if (hit_md)
      rd_mux = mdis_r[md_idx] & SKL_MDIS_MASK[md_idx];
  end

  // APB answer: data taken in setup, ready in access
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !hit_any;
      if (setup && !i_pwrite)
        prdata_r <= rd_mux;
    end
  end

  // Gate lock bit, writable only while unlocked
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      gate_lock_r <= SKL_GATE_LOCK_RST;
    else if (acc_wr && off == SKL_OFF_GATE && unlocked)
      gate_lock_r <= i_pwdata[SKL_GATE_LOCK_BIT];
  end

  // Power control, key protected
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      pwr_r <= SKL_PWR_RST;
    else if (acc_wr && off == SKL_OFF_PWR && unlocked)
      pwr_r <= i_pwdata[1:0];
  end

  // RAM execution boundary in 1 KB steps
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      exec_r <= SKL_EXEC_RST;
    else if (acc_wr && off == SKL_OFF_CFG)
      exec_r <= i_pwdata[7:0];
  end

  // Module disable registers with aliases
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mdis_r <= {SKL_NUM_MDIS{SKL_MDIS_RST}};
    end else if (acc_wr && hit_md && !gate_lock_r) begin
      mdis_r[md_idx] <= skl_alias(md_op, mdis_r[md_idx],
        i_pwdata, SKL_MDIS_MASK[md_idx]);
    end
  end

  // Fuse bits come from outside the clock domain
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fuse_s1_r <= 3'h0;
      fuse_s2_r <= 3'h0;
    end else begin
      fuse_s1_r <= {i_main_bor_en, i_low_power_brownout_enable,
                    i_retention_config_bit};
      fuse_s2_r <= fuse_s1_r;
    end
  end

  // Retention needs config bit zero and enable one
  assign ret_active = !fuse_s2_r[0] && pwr_r[SKL_RET_EN_BIT];

  // Sleep and wake sequencing
  always_comb begin
    ps_nxt = ps_r;
    case (ps_r)
      SKL_PS_RUN: begin
        if (i_sleep_req && (ret_active || !pwr_r[SKL_KEEPALIVE_BIT]))
          ps_nxt = SKL_PS_DEEP;
        else if (i_sleep_req)
          ps_nxt = SKL_PS_SLEEP;
      end
      SKL_PS_SLEEP: begin
        if (i_wake)
          ps_nxt = SKL_PS_RUN;
      end
      SKL_PS_DEEP: begin
        if (i_wake)
          ps_nxt = SKL_PS_WAKE;
      end
      SKL_PS_WAKE: begin
        if (tv_cnt_r == SKL_REGULATOR_STARTUP_DELAY_LAST)
          ps_nxt = SKL_PS_RUN;
      end
      default: ps_nxt = SKL_PS_RUN;
    endcase
  end

  // Power state
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      ps_r <= SKL_PS_RUN;
    else
      ps_r <= ps_nxt;
  end

  // Which deep mode was entered; frozen while asleep
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      deep_ret_r <= 1'b0;
    else if (ps_r == SKL_PS_RUN && i_sleep_req)
      deep_ret_r <= ret_active;
  end

  // Regulator start-up counter
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      tv_cnt_r <= 11'h000;
    else if (ps_r == SKL_PS_WAKE)
      tv_cnt_r <= tv_cnt_r + 11'h001;
    else
      tv_cnt_r <= 11'h000;
  end

  // Registered regulator controls
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl_r <= '0;
    end else begin
      ctl_r.main_standby <= ps_nxt == SKL_PS_DEEP && !deep_nxt_ret();
      ctl_r.main_off     <= ps_nxt == SKL_PS_DEEP && deep_nxt_ret();
      ctl_r.retention_on <= ps_nxt == SKL_PS_DEEP && deep_nxt_ret();
      ctl_r.exec_hold    <= ps_nxt == SKL_PS_WAKE;
    end
  end

  // Retention choice for the coming cycle
  function automatic logic deep_nxt_ret();
    return (ps_r == SKL_PS_RUN) ? ret_active : deep_ret_r;
  endfunction : deep_nxt_ret

  // Low-power detector only runs without the main one
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      lpbor_r <= 1'b0;
    else
      lpbor_r <= fuse_s2_r[1] && !fuse_s2_r[2];
  end

  // Outputs; disable bits gate peripheral clocks outside
  assign o_pready             = pready_r;
  assign o_pslverr            = pslverr_r;
  assign o_prdata             = prdata_r;
  assign o_module_disable_bit = mdis_r;
  assign o_reg_ctl            = ctl_r;
  assign o_lp_brownout_on     = lpbor_r;
  assign o_ram_exec_boundary  = exec_r;
  assign o_unlocked           = unlocked;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence s_deep_entry;
    ps_r == SKL_PS_DEEP ##1 i_wake;
  endsequence

  chk_pwr_locked: assert property (acc_wr && off == SKL_OFF_PWR &&
    !unlocked |=> $stable(pwr_r))
    else $error("power control changed while locked");
  chk_gate_locked: assert property (acc_wr && off == SKL_OFF_GATE &&
    !unlocked |=> $stable(gate_lock_r))
    else $error("gate lock changed while locked");
  chk_mdis_frozen: assert property (gate_lock_r && acc_wr && hit_md
    |-> !o_pslverr ##1 $stable(mdis_r))
    else $error("disable register changed under gate lock");
  chk_unimpl_zero: assert property ((mdis_r[0] & ~SKL_MDIS_MASK[0]) == 0 &&
    (mdis_r[4] & ~SKL_MDIS_MASK[4]) == 0)
    else $error("unimplemented disable bit set");
  chk_set_alias: assert property (acc_wr && hit_md && !gate_lock_r &&
    md_op == SKL_OP_SET |=> (mdis_r[$past(md_idx)] & $past(i_pwdata)
    & SKL_MDIS_MASK[$past(md_idx)]) == ($past(i_pwdata) & SKL_MDIS_MASK[$past(md_idx)]))
    else $error("set alias did not set bits");
  chk_key_read: assert property (setup && !i_pwrite && off == SKL_OFF_KEY
    |=> o_prdata == {31'h0, $past(unlocked)})
    else $error("key register read wrong state");
  chk_standby_entry: assert property (ps_r == SKL_PS_RUN && i_sleep_req &&
    !ret_active && !pwr_r[SKL_KEEPALIVE_BIT] |=> o_reg_ctl.main_standby)
    else $error("standby not entered on sleep");
  chk_retention_on: assert property (ps_r == SKL_PS_RUN && i_sleep_req &&
    ret_active |=> o_reg_ctl.retention_on && o_reg_ctl.main_off)
    else $error("retention regulator not enabled");
  chk_wake_hold: assert property (s_deep_entry |=>
    o_reg_ctl.exec_hold [*8] ##[1:1000] !o_reg_ctl.exec_hold)
    else $error("start-up hold wrong after wake");
  chk_lp_bor: assert property (o_lp_brownout_on |->
    ($past(fuse_s2_r) & 3'h4) == 3'h0)
    else $error("low-power detector on with main detector");

  // Bus answer, decode, alias and light-sleep wake checks
  chk_ready_setup: assert property (setup |=> o_pready)
    else $error("no ready in access cycle");
  chk_id_read: assert property (setup && !i_pwrite && off == SKL_OFF_ID
    |=> o_prdata == SKL_PART_ID)
    else $error("part identifier read wrong");
  chk_exec_write: assert property (acc_wr && off == SKL_OFF_CFG |=>
    {24'h000000, o_ram_exec_boundary} == ($past(i_pwdata) & 32'h000000ff))
    else $error("boundary field not written");
  chk_clr_alias: assert property (acc_wr && hit_md && !gate_lock_r &&
    md_op == SKL_OP_CLR |=> (mdis_r[$past(md_idx)] & $past(i_pwdata)) == 32'h00000000)
    else $error("clear alias did not clear bits");
  chk_wr_plain: assert property (acc_wr && hit_md && !gate_lock_r &&
    md_op == SKL_OP_WR |=> mdis_r[$past(md_idx)] == ($past(i_pwdata) & SKL_MDIS_MASK[$past(md_idx)]))
    else $error("plain disable write wrong");
  chk_light_wake: assert property (ps_r == SKL_PS_SLEEP && i_wake
    |=> o_reg_ctl == 4'h0)
    else $error("light sleep wake held execution");

  // Held-off cycles; far too many for a repetition, so counted here
  logic [10:0] hold_cnt_r;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      hold_cnt_r <= 11'h000;
    else if (o_reg_ctl.exec_hold)
      hold_cnt_r <= hold_cnt_r + 11'h001;
    else
      hold_cnt_r <= 11'h000;
  end

  chk_hold_bound: assert property (o_reg_ctl.exec_hold |->
    hold_cnt_r < 11'(SKL_REGULATOR_STARTUP_DELAY_CYC))
    else $error("start-up hold too long");
  chk_hold_span: assert property ($fell(o_reg_ctl.exec_hold) |->
    hold_cnt_r == 11'(SKL_REGULATOR_STARTUP_DELAY_CYC))
    else $error("start-up hold too short");
endmodule : skl_top
